/* File: core/gam_pkg.sv */
package gam_pkg;
	localparam int CLK_KHZ = 50000;
	localparam int ECU_TIMEOUT_MS = 3000;
	localparam int ECU_CYC = ECU_TIMEOUT_MS * CLK_KHZ;
	localparam int SVC_HOLD_MS = 5000;
	localparam int SVC_HOLD_CYC = SVC_HOLD_MS * CLK_KHZ;
	localparam int FLASH_MS = 500;
	localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;
	// Cooldown kept short enough for its cycle count to fit an int
	localparam int COOL_MS = 40000;
	localparam int COOL_CYC = COOL_MS * CLK_KHZ;
	localparam int PCT_BASE = 100;
	localparam int TRIP_PCT = 12;
	localparam int NSETS = 3;
	localparam int CNT_W = 16;
	localparam int FREQ_W = 16;
	localparam int TMR_W = 32;
	typedef enum logic [1:0] {
		LVL_NONE = 2'h0,
		LVL_WARN = 2'h1,
		LVL_DUMP = 2'h2,
		LVL_SHUT = 2'h3
	} gam_level_type;
	typedef enum logic [1:0] {
		OP_BACKUP = 2'h0,
		OP_PARALLEL = 2'h1,
		OP_TRANSFER = 2'h2
	} gam_op_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_START = 2'h1,
		ST_SYNC = 2'h3,
		ST_LOADED = 2'h2
	} gam_test_type;
endpackage

/* File: core/gam_alarm_manager.sv */
`timescale 1ns/1ps
module gam_alarm_manager #(
	parameter int NFAULT = 8,
	parameter int ECU_CYC = gam_pkg::ECU_CYC,
	parameter int HOLD_CYC = gam_pkg::SVC_HOLD_CYC,
	parameter int FLASH_CYC = gam_pkg::FLASH_CYC,
	parameter int COOL_CYC = gam_pkg::COOL_CYC
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Pins: fault causes, keys, engine and busbar state
	input wire logic [NFAULT-1:0] fault_cause,
	input wire logic mute_key,
	input wire logic indicator_check_key,
	input wire logic load_test_key,
	input wire logic mode_key,
	input wire logic protect_override,
	input wire logic ecu_msg,
	input wire logic hour_tick,
	input wire logic day_tick,
	input wire logic busbar_live,
	input wire logic busbar_power_ok,
	input wire logic sync_done,
	input wire logic engine_running,
	input wire logic fuel_on,
	// Configuration
	input wire logic [NFAULT-1:0][1:0] fault_level_cfg,
	input wire logic [NFAULT-1:0] fault_latch_cfg,
	input wire gam_pkg::gam_level_type ecu_level,
	input wire gam_pkg::gam_level_type svc_level,
	input wire gam_pkg::gam_op_type op_mode,
	input wire logic [gam_pkg::FREQ_W-1:0] gen_freq,
	input wire logic [gam_pkg::FREQ_W-1:0] freq_high_limit,
	input wire logic [gam_pkg::NSETS-1:0][gam_pkg::CNT_W-1:0] svc_hours_limit,
	input wire logic [gam_pkg::NSETS-1:0][gam_pkg::CNT_W-1:0] svc_time_limit,
	// Non-volatile store
	input wire logic nv_restore,
	input wire logic [gam_pkg::NSETS-1:0][gam_pkg::CNT_W-1:0] nv_hours_in,
	input wire logic [gam_pkg::NSETS-1:0][gam_pkg::CNT_W-1:0] nv_time_in,
	output logic [gam_pkg::NSETS-1:0][gam_pkg::CNT_W-1:0] nv_hours,
	output logic [gam_pkg::NSETS-1:0][gam_pkg::CNT_W-1:0] nv_time,
	output logic nv_write,
	// Indicators and actuators
	output logic alarm_led,
	output logic warning_led,
	output logic alarm_out,
	output logic service_led,
	output logic service_out,
	output logic gen_contactor,
	output logic engine_stop,
	output logic engine_run,
	output logic remote_start,
	output logic sync_req,
	output logic ramp_share
);
	import gam_pkg::*;

	localparam int NSRC = NFAULT + 3;
	localparam int SRC_ECU = NFAULT;
	localparam int SRC_TRIP = NFAULT + 1;
	localparam int SRC_SVC = NFAULT + 2;
	localparam int NPIN = NFAULT + 13;

	if (NFAULT < 1 || ECU_CYC < 2 || HOLD_CYC < 2 || FLASH_CYC < 2 ||
		COOL_CYC < 2) begin : g_bad_param
		$error("gam_alarm_manager: parameter out of range");
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Pin synchronisers; edges taken from the second stage only
	logic [NPIN-1:0] pin_s1, pin_s2, pin_d;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_d <= '0;
		end else if (clk_en) begin
			pin_s1 <= {fuel_on, engine_running, sync_done, busbar_power_ok,
				busbar_live, day_tick, hour_tick, ecu_msg, protect_override,
				mode_key, load_test_key, indicator_check_key, mute_key,
				fault_cause};
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	logic [NPIN-1:0] pin_rise;
	assign pin_rise = pin_s2 & ~pin_d;
	logic mute_s, check_s, override_s, live_s, power_s, sync_s;
	logic running_s, fuel_s, mute_press, test_press, mode_press;
	logic msg_edge, hour_edge, day_edge;
	assign mute_s = pin_s2[NFAULT];
	assign check_s = pin_s2[NFAULT+1];
	assign override_s = pin_s2[NFAULT+4];
	assign live_s = pin_s2[NFAULT+8];
	assign power_s = pin_s2[NFAULT+9];
	assign sync_s = pin_s2[NFAULT+10];
	assign running_s = pin_s2[NFAULT+11];
	assign fuel_s = pin_s2[NFAULT+12];
	assign mute_press = pin_rise[NFAULT];
	assign test_press = pin_rise[NFAULT+2];
	assign mode_press = test_press | pin_rise[NFAULT+3];
	assign msg_edge = pin_rise[NFAULT+5];
	assign hour_edge = pin_rise[NFAULT+6];
	assign day_edge = pin_rise[NFAULT+7];

	// Engine link watchdog, armed only while fuel is on
	logic [TMR_W-1:0] ecu_cnt;
	logic ecu_fail;
	assign ecu_fail = fuel_s && ecu_cnt == TMR_W'(ECU_CYC - 1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ecu_cnt <= '0;
		end else if (clk_en) begin
			if (!fuel_s || msg_edge) begin
				ecu_cnt <= '0;
			end else if (!ecu_fail) begin
				ecu_cnt <= ecu_cnt + 1'b1;
			end
		end
	end

	// Overspeed trip compares scaled values; no divider needed
	logic [23:0] freq_scaled, trip_scaled;
	logic trip_cause;
	assign freq_scaled = 24'(gen_freq) * 24'(PCT_BASE);
	assign trip_scaled = 24'(freq_high_limit) * 24'(PCT_BASE + TRIP_PCT);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trip_cause <= 1'b0;
		end else if (clk_en) begin
			trip_cause <= freq_scaled > trip_scaled;
		end
	end

	// Service counter sets
	logic [CNT_W-1:0] rem_h [NSETS];
	logic [CNT_W-1:0] rem_t [NSETS];
	logic [NSETS-1:0] svc_exp, svc_dec;
	logic [TMR_W-1:0] hold_cnt;
	logic svc_reload;
	assign svc_reload = hold_cnt == TMR_W'(HOLD_CYC - 1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_cnt <= '0;
		end else if (clk_en) begin
			if (!(mute_s && check_s)) begin
				hold_cnt <= '0;
			end else if (hold_cnt != TMR_W'(HOLD_CYC)) begin
				hold_cnt <= hold_cnt + 1'b1;
			end
		end
	end

	for (genvar s = 0; s < NSETS; s++) begin : g_svc
		logic h_on, t_on;
		assign h_on = svc_hours_limit[s] != '0;
		assign t_on = svc_time_limit[s] != '0;
		assign svc_exp[s] = h_on && (rem_h[s] == '0 ||
			(t_on && rem_t[s] == '0));
		assign svc_dec[s] = h_on && ((hour_edge && running_s &&
			rem_h[s] != '0) || (day_edge && t_on && rem_t[s] != '0));
		assign nv_hours[s] = rem_h[s];
		assign nv_time[s] = rem_t[s];
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				rem_h[s] <= '0;
				rem_t[s] <= '0;
			end else if (clk_en) begin
				if (svc_reload) begin
					rem_h[s] <= svc_hours_limit[s];
					rem_t[s] <= svc_time_limit[s];
				end else if (nv_restore) begin
					rem_h[s] <= nv_hours_in[s];
					rem_t[s] <= nv_time_in[s];
				end else if (h_on) begin
					if (hour_edge && running_s && rem_h[s] != '0) begin
						rem_h[s] <= rem_h[s] - 1'b1;
					end
					if (day_edge && t_on && rem_t[s] != '0) begin
						rem_t[s] <= rem_t[s] - 1'b1;
					end
				end
			end
		end
	end

	// Fault sources and their effective severities
	logic [NSRC-1:0] cause, latch, held, accept;
	logic [NSRC-1:0] acc_shut, acc_dump, acc_warn;
	logic [NSRC-1:0] is_shut, is_dump, is_warn;
	gam_level_type cfg_lvl [NSRC];
	gam_level_type eff_lvl [NSRC];
	gam_level_type held_lvl [NSRC];
	logic held_sd, held_ld, held_wn;
	assign held_sd = |is_shut;
	assign held_ld = |is_dump;
	assign held_wn = |is_warn;
	assign cause = {(|svc_exp) && svc_level != LVL_NONE, trip_cause,
		ecu_fail && ecu_level != LVL_NONE, pin_s2[NFAULT-1:0]};
	assign latch = {1'b0, 1'b1, 1'b0, fault_latch_cfg};

	for (genvar i = 0; i < NSRC; i++) begin : g_src
		if (i < NFAULT) begin : g_ext
			assign cfg_lvl[i] = gam_level_type'(fault_level_cfg[i]);
		end else if (i == SRC_ECU) begin : g_ecu
			assign cfg_lvl[i] = ecu_level;
		end else if (i == SRC_TRIP) begin : g_trip
			assign cfg_lvl[i] = LVL_SHUT;
		end else begin : g_svl
			assign cfg_lvl[i] = svc_level;
		end
		// The overspeed trip is never downgraded by the override
		assign eff_lvl[i] = (override_s && i != SRC_TRIP &&
			cfg_lvl[i] >= LVL_DUMP) ? LVL_WARN : cfg_lvl[i];
		// A cause with level none is folded into warning
		assign acc_shut[i] = cause[i] && !held[i] &&
			eff_lvl[i] == LVL_SHUT && !held_sd;
		assign acc_dump[i] = cause[i] && !held[i] &&
			eff_lvl[i] == LVL_DUMP && !held_sd && !held_ld;
		assign acc_warn[i] = cause[i] && !held[i] &&
			eff_lvl[i] <= LVL_WARN && !held_sd && !held_ld &&
			!held_wn;
		assign accept[i] = acc_shut[i] | acc_dump[i] | acc_warn[i];
		assign is_shut[i] = held[i] && held_lvl[i] == LVL_SHUT;
		assign is_dump[i] = held[i] && held_lvl[i] == LVL_DUMP;
		assign is_warn[i] = held[i] && held_lvl[i] == LVL_WARN;
		// A new acceptance wins over a mode-key clear in the same cycle
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				held[i] <= 1'b0;
				held_lvl[i] <= LVL_NONE;
			end else if (clk_en) begin
				if (accept[i]) begin
					held[i] <= 1'b1;
					held_lvl[i] <= (eff_lvl[i] == LVL_NONE) ?
						LVL_WARN : eff_lvl[i];
				end else if (mode_press) begin
					held[i] <= 1'b0;
				end else if (!cause[i] && !latch[i]) begin
					held[i] <= 1'b0;
				end
			end
		end
	end

	// Mute and cooldown
	logic muted;
	logic [TMR_W-1:0] cool_cnt;
	logic cool_done;
	assign cool_done = cool_cnt == TMR_W'(COOL_CYC - 1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			muted <= 1'b0;
		end else if (clk_en) begin
			if (|accept) begin
				muted <= 1'b0;
			end else if (mute_press) begin
				muted <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cool_cnt <= '0;
		end else if (clk_en) begin
			if (!held_ld) begin
				cool_cnt <= '0;
			end else if (!cool_done) begin
				cool_cnt <= cool_cnt + 1'b1;
			end
		end
	end

	// Load test sequencer
	gam_test_type state, next_state;
	logic test_on, inhibit, paralleled;
	assign inhibit = held_sd | held_ld;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			test_on <= 1'b0;
		end else if (clk_en && mode_press) begin
			test_on <= test_press;
		end
	end
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (test_on && !inhibit) begin
					next_state = ST_START;
				end
			end
			ST_START: begin
				if (running_s) begin
					unique case (op_mode)
						OP_PARALLEL: next_state = live_s ? ST_SYNC :
							ST_LOADED;
						OP_TRANSFER: next_state = power_s ? ST_LOADED :
							ST_START;
						default: next_state = ST_LOADED;
					endcase
				end
			end
			ST_SYNC: begin
				if (sync_s) begin
					next_state = ST_LOADED;
				end
			end
			ST_LOADED: begin
				next_state = ST_LOADED;
			end
		endcase
		if (!test_on || inhibit) begin
			next_state = ST_IDLE;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			paralleled <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			if (state == ST_SYNC && next_state == ST_LOADED) begin
				paralleled <= 1'b1;
			end else if (next_state == ST_IDLE) begin
				paralleled <= 1'b0;
			end
		end
	end

	// Service lamp flash phase
	logic [TMR_W-1:0] flash_cnt;
	logic flash_ph;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flash_cnt <= '0;
			flash_ph <= 1'b0;
		end else if (clk_en) begin
			if (flash_cnt == TMR_W'(FLASH_CYC - 1)) begin
				flash_cnt <= '0;
				flash_ph <= ~flash_ph;
			end else begin
				flash_cnt <= flash_cnt + 1'b1;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alarm_led <= 1'b0;
			warning_led <= 1'b0;
			alarm_out <= 1'b0;
			gen_contactor <= 1'b0;
			engine_stop <= 1'b0;
			engine_run <= 1'b0;
			remote_start <= 1'b0;
			sync_req <= 1'b0;
			ramp_share <= 1'b0;
			service_led <= 1'b0;
			service_out <= 1'b0;
			nv_write <= 1'b0;
		end else if (clk_en) begin
			alarm_led <= held_sd | held_ld;
			warning_led <= held_wn;
			alarm_out <= (|held) && !muted;
			gen_contactor <= state == ST_LOADED && !inhibit;
			engine_stop <= held_sd | trip_cause |
				(held_ld && cool_done);
			engine_run <= test_on && !inhibit;
			remote_start <= test_on && !inhibit &&
				op_mode == OP_TRANSFER;
			sync_req <= state == ST_SYNC;
			ramp_share <= state == ST_LOADED && paralleled;
			service_led <= (|svc_exp) && flash_ph;
			service_out <= |svc_exp;
			nv_write <= (|svc_dec) | svc_reload;
		end
	end

	sequence s_mute_quiet;
		mute_press && clk_en && !(|accept) ##1 clk_en && !(|accept);
	endsequence

	a_shut_stops: assert property (held_sd && clk_en |=>
		engine_stop && !gen_contactor && alarm_led)
		else $error("shutdown did not stop engine and open contactor");
	a_dump_wait: assert property (held_ld && !held_sd && !trip_cause &&
		cool_cnt == '0 && clk_en |=> !engine_stop && !gen_contactor)
		else $error("load dump stopped engine before cooldown");
	a_warn_runs: assert property (held_wn && !inhibit && !trip_cause &&
		clk_en |=> !engine_stop && warning_led)
		else $error("warning affected engine");
	a_shut_refuse: assert property (held_sd |-> accept == '0)
		else $error("fault accepted under shutdown");
	a_dump_refuse: assert property (held_ld |->
		(acc_dump | acc_warn) == '0)
		else $error("dump or warning accepted under dump");
	a_warn_refuse: assert property (held_wn |-> acc_warn == '0)
		else $error("warning accepted under warning");
	a_mute_silent: assert property (s_mute_quiet |=> !alarm_out)
		else $error("alarm output still on after mute");
	a_mode_clears: assert property (mode_press && clk_en &&
		accept == '0 |=> held == '0)
		else $error("mode key left faults held");
	a_trip_stops: assert property (trip_cause && clk_en |=>
		engine_stop)
		else $error("overspeed trip did not stop engine");
	a_ecu_watch: assert property (!fuel_s && clk_en |=>
		ecu_cnt == '0)
		else $error("link watchdog ran with fuel off");
endmodule // gam_alarm_manager

/* File: verif/gam_engine_model.sv */
`timescale 1ns/1ps
module gam_engine_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Commands from the controller
	input wire logic engine_run,
	input wire logic engine_stop,
	input wire logic remote_start,
	input wire logic sync_req,
	// Engine and busbar state
	output logic engine_running,
	output logic busbar_power_ok,
	output logic sync_done
);
	logic [2:0] spin;
	logic [1:0] lag;
	// Engine needs several cycles to fire; a stop drops it at once
	always_ff @(posedge clk) begin
		if (!rst_n || !engine_run || engine_stop) begin
			spin <= 3'h0;
		end else if (spin != 3'h7) begin
			spin <= spin + 3'h1;
		end
	end
	assign engine_running = (spin == 3'h7);
	// Busbar power appears only once the remote group is up
	always_ff @(posedge clk) begin
		busbar_power_ok <= rst_n && remote_start && engine_running;
	end
	// Phase matching takes a few cycles, never instant
	always_ff @(posedge clk) begin
		if (!rst_n || !sync_req) begin
			lag <= 2'h0;
		end else if (lag != 2'h3) begin
			lag <= lag + 2'h1;
		end
	end
	assign sync_done = sync_req && (lag == 2'h3);
endmodule // gam_engine_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
	import gam_pkg::*;
	logic clk = 0, rst_n = 0, fuel_on = 0, busbar_live = 0, ecu_msg = 0;
	logic mute_key = 0, indicator_check_key = 0, load_test_key = 0;
	logic mode_key = 0, protect_override = 0, hour_tick = 0, day_tick = 0;
	logic nv_restore = 0, engine_running, busbar_power_ok, sync_done;
	logic clk_en = 1'b1, nv_write;
	logic [7:0] latch_cfg = 8'h08;
	int nv_pulses = 0;
	logic [7:0] cause = 8'h00;
	logic [7:0][1:0] lvl_cfg = 16'h01E7; // 0 shut,1 warn,2 dump,3 shut,4 warn
	gam_level_type ecu_level = LVL_NONE, svc_level = LVL_NONE;
	gam_op_type op_mode = OP_BACKUP;
	logic [15:0] gen_freq = 16'h0050, freq_high_limit = 16'h0064;
	logic [2:0][15:0] hlim = '0, tlim = '0, hin = '0;
	logic [2:0][15:0] nv_hours, nv_time;
	logic alarm_led, warning_led, alarm_out, service_led, service_out;
	logic gen_contactor, engine_stop, engine_run, remote_start, sync_req;
	logic ramp_share;
	int bad_count = 0, check_count = 0;
	always #10 clk = ~clk;
	// Store pulses last one cycle; counted away from the launching edge
	always @(negedge clk) begin
		if (nv_write) begin
			nv_pulses++;
		end
	end
	gam_alarm_manager #(.ECU_CYC(20), .HOLD_CYC(10), .FLASH_CYC(4),
		.COOL_CYC(40)) i_gam_alarm_manager (.clk(clk), .rst_n(rst_n),
		.clk_en(clk_en), .fault_cause(cause), .mute_key(mute_key),
		.indicator_check_key(indicator_check_key),
		.load_test_key(load_test_key), .mode_key(mode_key),
		.protect_override(protect_override), .ecu_msg(ecu_msg),
		.hour_tick(hour_tick), .day_tick(day_tick),
		.busbar_live(busbar_live), .busbar_power_ok(busbar_power_ok),
		.sync_done(sync_done), .engine_running(engine_running),
		.fuel_on(fuel_on), .fault_level_cfg(lvl_cfg),
		.fault_latch_cfg(latch_cfg), .ecu_level(ecu_level),
		.svc_level(svc_level), .op_mode(op_mode), .gen_freq(gen_freq),
		.freq_high_limit(freq_high_limit), .svc_hours_limit(hlim),
		.svc_time_limit(tlim), .nv_restore(nv_restore), .nv_hours_in(hin),
		.nv_time_in(hin), .nv_hours(nv_hours), .nv_time(nv_time),
		.nv_write(nv_write), .alarm_led(alarm_led),
		.warning_led(warning_led),
		.alarm_out(alarm_out), .service_led(service_led),
		.service_out(service_out), .gen_contactor(gen_contactor),
		.engine_stop(engine_stop), .engine_run(engine_run),
		.remote_start(remote_start), .sync_req(sync_req),
		.ramp_share(ramp_share));
	gam_engine_model i_gam_engine_model (.clk(clk), .rst_n(rst_n),
		.engine_run(engine_run), .engine_stop(engine_stop),
		.remote_start(remote_start), .sync_req(sync_req),
		.engine_running(engine_running), .busbar_power_ok(busbar_power_ok),
		.sync_done(sync_done));
	task tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Keys: check, mute, test, mode; held n cycles then released
	task keys(input logic [3:0] v, input int n);
		{indicator_check_key, mute_key, load_test_key, mode_key} = v;
		tick(n);
		{indicator_check_key, mute_key, load_test_key, mode_key} = 4'h0;
		tick(6);
	endtask
	task t_shutdown;
		cause[0] = 1'b1;
		tick(6);
		check("alarm_led", alarm_led, 1'b1);
		check("alarm_out", alarm_out, 1'b1);
		check("engine_stop", engine_stop, 1'b1);
		check("gen_contactor", gen_contactor, 1'b0);
		cause[2:1] = 2'h3;
		tick(6);
		check("warning_led", warning_led, 1'b0);
		keys(4'h4, 4);
		check("alarm_out", alarm_out, 1'b0);
		check("alarm_led", alarm_led, 1'b1);
		cause = 8'h00;
		keys(4'h1, 4);
		$display("t_shutdown done");
	endtask
	task t_dump;
		cause[2] = 1'b1;
		tick(6);
		check("alarm_led", alarm_led, 1'b1);
		check("alarm_out", alarm_out, 1'b1);
		check("gen_contactor", gen_contactor, 1'b0);
		cause[1] = 1'b1;
		tick(25);
		check("warning_led", warning_led, 1'b0);
		check("engine_stop", engine_stop, 1'b0);
		tick(14);
		check("engine_stop", engine_stop, 1'b1);
		cause = 8'h00;
		keys(4'h1, 4);
		cause[2] = 1'b1;
		tick(6);
		cause[0] = 1'b1;
		tick(6);
		check("engine_stop", engine_stop, 1'b1);
		cause = 8'h00;
		keys(4'h1, 4);
		$display("t_dump done");
	endtask
	task t_warn;
		cause[1] = 1'b1;
		tick(6);
		check("warning_led", warning_led, 1'b1);
		check("alarm_out", alarm_out, 1'b1);
		check("engine_stop", engine_stop, 1'b0);
		keys(4'h4, 4);
		cause[4] = 1'b1;
		tick(6);
		check("alarm_out", alarm_out, 1'b0);
		cause[2] = 1'b1;
		tick(6);
		check("alarm_out", alarm_out, 1'b1);
		check("alarm_led", alarm_led, 1'b1);
		cause = 8'h00;
		keys(4'h1, 4);
		$display("t_warn done");
	endtask
	task t_latch_override;
		cause[3] = 1'b1;
		tick(6);
		cause = 8'h00;
		tick(8);
		check("alarm_led", alarm_led, 1'b1);
		check("engine_stop", engine_stop, 1'b1);
		keys(4'h1, 4);
		check("alarm_led", alarm_led, 1'b0);
		protect_override = 1'b1;
		cause[0] = 1'b1;
		tick(6);
		check("warning_led", warning_led, 1'b1);
		check("engine_stop", engine_stop, 1'b0);
		cause = 8'h00;
		protect_override = 1'b0;
		keys(4'h1, 4);
		gen_freq = 16'h0070;
		tick(8);
		check("engine_stop", engine_stop, 1'b0);
		gen_freq = 16'h0071;
		tick(8);
		check("engine_stop", engine_stop, 1'b1);
		gen_freq = 16'h0050;
		keys(4'h1, 4);
		latch_cfg[1] = 1'b1;
		cause[1] = 1'b1;
		tick(6);
		cause = 8'h00;
		tick(8);
		check("warning_led", warning_led, 1'b1);
		keys(4'h1, 4);
		check("warning_led", warning_led, 1'b0);
		latch_cfg[1] = 1'b0;
		$display("t_latch_override done");
	endtask
	task t_link;
		ecu_level = LVL_WARN;
		fuel_on = 1'b1;
		repeat (6) begin
			ecu_msg = ~ecu_msg;
			tick(8);
		end
		check("warning_led", warning_led, 1'b0);
		tick(30);
		check("warning_led", warning_led, 1'b1);
		fuel_on = 1'b0;
		keys(4'h1, 4);
		tick(30);
		check("warning_led", warning_led, 1'b0);
		ecu_level = LVL_NONE;
		$display("t_link done");
	endtask
	task t_service;
		logic s;
		int p;
		p = nv_pulses;
		svc_level = LVL_WARN;
		tlim[1] = 16'h0001;
		tick(8);
		check("service_out", service_out, 1'b0);
		hlim[0] = 16'h0002;
		tlim[0] = 16'h0001;
		tick(8);
		check("service_out", service_out, 1'b1);
		check("warning_led", warning_led, 1'b1);
		s = service_led;
		tick(4);
		check("service_led", service_led, !s);
		clk_en = 1'b0;
		s = service_led;
		tick(6);
		check("service_led", service_led, s);
		clk_en = 1'b1;
		keys(4'hC, 16);
		check("nv_hours0", nv_hours[0], 16'h0002);
		check("service_out", service_out, 1'b0);
		hour_tick = 1'b1;
		day_tick = 1'b1;
		tick(4);
		{hour_tick, day_tick} = 2'h0;
		tick(6);
		check("nv_hours0", nv_hours[0], 16'h0002);
		check("service_out", service_out, 1'b1);
		hin[2] = 16'h0123;
		nv_restore = 1'b1;
		tick(1);
		nv_restore = 1'b0;
		tick(4);
		check("nv_time2", nv_time[2], 16'h0123);
		check("nv_write", 16'(nv_pulses - p), 16'h0002);
		hlim = '0;
		tlim = '0;
		svc_level = LVL_NONE;
		keys(4'h1, 4);
		$display("t_service done");
	endtask
	task t_load_test;
		logic sy;
		for (int m = 0; m < 4; m++) begin
			op_mode = gam_op_type'(m == 3 ? 2 : (m == 2 ? 1 : m));
			busbar_live = (m == 1);
			sy = 1'b0;
			keys(4'h2, 4);
			for (int i = 0; i < 60 && gen_contactor !== 1'b1; i++) begin
				sy |= sync_req;
				tick(1);
			end
			check("gen_contactor", gen_contactor, 1'b1);
			check("engine_run", engine_run, 1'b1);
			check("sync_req", sy, m == 1);
			check("ramp_share", ramp_share, m == 1);
			check("remote_start", remote_start, m == 3);
			keys(4'h1, 4);
			check("engine_run", engine_run, 1'b0);
		end
		busbar_live = 1'b0;
		$display("t_load_test done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole sequence needs under 800 cycles; allow 20000, over 25 times that
	initial begin
		#400000;
		$display("Error watchdog expired");
		bad_count++;
		final_report;
	end
	initial begin
		tick(20);
		rst_n = 1'b1;
		tick(2);
		t_shutdown;
		t_dump;
		t_warn;
		t_latch_override;
		t_link;
		t_service;
		t_load_test;
		final_report;
	end
endmodule // tb
